// >>> core/scp_pkg.sv
// Constants and types of the system clock and power mode controller
package scp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock rates and derived counts
    localparam int unsigned CLK_HZ     = 25_000_000;
    localparam int unsigned SUB_HZ     = 32_768;
    localparam int unsigned SUB_DIV    = CLK_HZ / SUB_HZ;
    localparam int unsigned HS_START   = 1024;
    localparam int unsigned DIV_W      = 6;
    localparam int unsigned WDT_PRE    = 4;

    ////////////////////////////////////////////////////////////////////////
    // Clock source codes: 0 sub clock, 1..6 high/64..high/2, 7 high
    localparam logic [2:0] SRC_SUB     = 3'h0;
    localparam logic [2:0] SRC_HIGH    = 3'h7;
    localparam logic [2:0] CKS_SUB_MAX = 3'h1;
    localparam logic [2:0] CKS_OFFSET  = 3'h1;
    localparam int unsigned IDLE_KEEP_BIT = 7;

    ////////////////////////////////////////////////////////////////////////
    // Configuration option codes
    localparam logic OSC_RC      = 1'b0;
    localparam logic OSC_CRYSTAL = 1'b1;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_SLOW,
        MODE_DEEP_HALT,
        MODE_HALT_SUB,
        MODE_IDLE_OFF,
        MODE_IDLE_ON
    } scp_mode_t;

endpackage : scp_pkg

// >>> core/scp_clock_power.sv
// System clock selection and operating mode sequencer
//
// Contract
// - System clock picks high family or sub clock from select bit and divider field.
// - High clock comes from crystal or RC, fixed by configuration parameter.
// - Sub clock comes from crystal or RC, fixed by configuration parameter.
// - High clock offered whole or divided by 2 down to 64.
// - After wake-up the sub clock can stand in until high clock is ready.
// - Sub clock feeds watchdog, time base, timers, LCD and serial module.
// - Switching from high clock to sub clock stops the high oscillator.
// - Six modes: two run modes, four modes with CPU clock stopped.
// - Normal mode clocks CPU from high clock divided 1..64; sub clock runs.
// - Slow mode clocks CPU from sub clock with high clock off.
// - Halt with idle enable low enters one of the sleep modes.
// - Deep halt stops CPU, sub clock and watchdog clock; watchdog disabled.
// - Deep halt refused while voltage detect or LCD driver enabled.
// - Halt-sub mode keeps sub clock, and watchdog clock when fed by sub clock, for detect, LCD or watchdog.
// - Halt with idle enable and keep-on low enters idle with clock off.
// - Idle-off: watchdog clock off if fed by sysclk/4, on if sub clock.
// - Idle-off keeps sub clock peripherals running while CPU stops.
// - Idle with keep-on high keeps system clock and watchdog clock running.
// - With select low, divider 000/001 give sub, 010..111 give high/64..2.
// - Select high gives the undivided high clock as system clock.
// - Idle keep-on control sits at bit 7 of system control register.
`timescale 1ns/1ns

module scp_clock_power #(
    parameter logic        HIGH_OSC_CFG = scp_pkg::OSC_CRYSTAL,
    parameter logic        LOW_OSC_CFG  = scp_pkg::OSC_CRYSTAL,
    parameter int unsigned SUB_DIV      = scp_pkg::SUB_DIV,
    parameter int unsigned HS_START     = scp_pkg::HS_START
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       highLowClockSelect,
    input  wire logic [2:0] clockDividerSelect,
    input  wire logic       idleOnHaltEnable,
    input  wire logic [7:0] systemControlReg,
    input  wire logic       voltageDetectEnable,
    input  wire logic       lcdDriverEnable,
    input  wire logic       watchdogEnable,
    input  wire logic       watchdogSrcSub,
    input  wire logic       fastWakeEnable,
    input  wire logic       haltExec,
    input  wire logic       wakeUp,
    output logic            sysClkTick,
    output logic            cpuClkTick,
    output logic            subClkTick,
    output logic            watchdogClkTick,
    output logic            highClkTick,
    output logic            highCrystalOscEn,
    output logic            highRcOscEn,
    output logic            lowCrystalOscEn,
    output logic            lowRcOscEn,
    output logic            highReady,
    output logic [2:0]      operatingMode
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Selection bits to source code
    function automatic logic [2:0] srcCode(input logic hl,
                                           input logic [2:0] cks);
        if (hl)
            srcCode = scp_pkg::SRC_HIGH;
        else if (cks <= scp_pkg::CKS_SUB_MAX)
            srcCode = scp_pkg::SRC_SUB;
        else
            srcCode = cks - scp_pkg::CKS_OFFSET;
    endfunction : srcCode

    // Tick of high clock divided by 2^(7-code)
    function automatic logic divTick(input logic [2:0] code,
                                     input logic [5:0] cnt);
        logic [5:0] mask;
        mask = 6'h3f >> (code - 3'h1);
        divTick = (cnt & mask) == mask;
    endfunction : divTick

    localparam logic [15:0] SUB_LAST  = 16'(SUB_DIV - 1);
    localparam logic [10:0] HS_LAST   = 11'(HS_START - 1);
    localparam logic [1:0]  WDT_LAST  = 2'(scp_pkg::WDT_PRE - 1);

    ////////////////////////////////////////////////////////////////////////
    // State

    scp_pkg::scp_mode_t mode_q, mode_d;
    logic [2:0]  src_q, src_d;
    logic [15:0] subCnt_q, subCnt_d;
    logic [5:0]  divCnt_q, divCnt_d;
    logic [10:0] startCnt_q, startCnt_d;
    logic [1:0]  wdtCnt_q, wdtCnt_d;
    logic        highReady_q, highReady_d;
    logic        fastWake_q, fastWake_d;
    logic        sysTick_q, cpuTick_q, subTick_q, wdtTick_q, highTick_q;
    logic        sysTick_d, cpuTick_d, subTick_d, wdtTick_d, highTick_d;
    logic        highOn_q, highOn_d;
    logic        subOn_q, subOn_d;

    logic [2:0]  reqSrc;
    logic        subNow, highNow, curTick, keepSub, idleKeep, running;

    always_comb begin
        idleKeep = systemControlReg[scp_pkg::IDLE_KEEP_BIT];
        reqSrc   = srcCode(highLowClockSelect, clockDividerSelect);
        keepSub  = voltageDetectEnable | lcdDriverEnable
                 | (watchdogEnable & watchdogSrcSub);
        running  = (mode_q == scp_pkg::MODE_NORMAL)
                 | (mode_q == scp_pkg::MODE_SLOW);
        mode_d      = mode_q;
        fastWake_d  = fastWake_q;
        highReady_d = highReady_q;
        startCnt_d  = startCnt_q;

        // Sub clock divider, stopped only in deep halt
        subNow   = subOn_q && (subCnt_q == SUB_LAST);
        subCnt_d = !subOn_q ? 16'h0 : subNow ? 16'h0 : subCnt_q + 16'h1;
        highNow  = highOn_q;
        divCnt_d = highOn_q ? divCnt_q + 6'h1 : 6'h0;

        // Active source tick, gates source changes
        if (src_q == scp_pkg::SRC_SUB)
            curTick = subNow;
        else
            curTick = highNow & highReady_q & divTick(src_q, divCnt_q);
        src_d = src_q;
        if (fastWake_q)
            src_d = scp_pkg::SRC_SUB;
        else if (curTick || (src_q != scp_pkg::SRC_SUB && !highReady_q))
            src_d = reqSrc;

        if (running && haltExec) begin
            if (!idleOnHaltEnable) begin
                // Detect or LCD forbids deep halt
                if (keepSub)
                    mode_d = scp_pkg::MODE_HALT_SUB;
                else
                    mode_d = scp_pkg::MODE_DEEP_HALT;
            end else if (idleKeep) begin
                mode_d = scp_pkg::MODE_IDLE_ON;
            end else begin
                mode_d = scp_pkg::MODE_IDLE_OFF;
            end
        end else if (!running && wakeUp) begin
            mode_d = (reqSrc == scp_pkg::SRC_SUB) ? scp_pkg::MODE_SLOW
                                                  : scp_pkg::MODE_NORMAL;
            // Sub clock stands in while high restarts
            fastWake_d = fastWakeEnable && reqSrc != scp_pkg::SRC_SUB
                       && !highReady_q
                       && mode_q != scp_pkg::MODE_DEEP_HALT
                       && HIGH_OSC_CFG == scp_pkg::OSC_CRYSTAL;
        end else if (running) begin
            // Pending switch to high stays normal, so high osc keeps running
            mode_d = (src_q == scp_pkg::SRC_SUB && !fastWake_q
                      && reqSrc == scp_pkg::SRC_SUB)
                   ? scp_pkg::MODE_SLOW : scp_pkg::MODE_NORMAL;
        end

        // High oscillator off when sub clock drives system, except during fast wake or a pending switch to high
        // Slow mode keeps high clock off
        case (mode_d)
            scp_pkg::MODE_NORMAL:    highOn_d = 1'b1;
            scp_pkg::MODE_IDLE_ON:   highOn_d = src_q != scp_pkg::SRC_SUB;
            default:                 highOn_d = 1'b0;
        endcase
        if (mode_d == scp_pkg::MODE_NORMAL && src_q == scp_pkg::SRC_SUB
            && reqSrc == scp_pkg::SRC_SUB && !fastWake_d)
            highOn_d = 1'b0;
        subOn_d = mode_d != scp_pkg::MODE_DEEP_HALT;

        // Startup count of high clock after it restarts
        if (!highOn_q) begin
            highReady_d = 1'b0;
            startCnt_d  = 11'h0;
        end else if (!highReady_q) begin
            startCnt_d  = startCnt_q + 11'h1;
            highReady_d = startCnt_q == HS_LAST;
        end
        if (highReady_q && fastWake_q)
            fastWake_d = 1'b0;

        // Sub clock peripherals unaffected by CPU stop except in deep halt
        sysTick_d = curTick && mode_q != scp_pkg::MODE_IDLE_OFF
                 && mode_q != scp_pkg::MODE_DEEP_HALT
                 && mode_q != scp_pkg::MODE_HALT_SUB;
        // CPU clock only in run modes
        cpuTick_d = curTick & running;
        subTick_d = subNow;
        highTick_d = highNow & highReady_q;

        wdtCnt_d = wdtCnt_q;
        if (watchdogSrcSub) begin
            wdtTick_d = subNow;
        end else begin
            wdtTick_d = sysTick_d && wdtCnt_q == WDT_LAST;
            if (sysTick_d)
                wdtCnt_d = wdtCnt_q + 2'h1;
        end
        // Watchdog clock stopped in deep halt
        if (mode_q == scp_pkg::MODE_DEEP_HALT)
            wdtTick_d = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q      <= scp_pkg::MODE_NORMAL;
            src_q       <= scp_pkg::SRC_HIGH;
            subCnt_q    <= 16'h0;
            divCnt_q    <= 6'h0;
            startCnt_q  <= 11'h0;
            wdtCnt_q    <= 2'h0;
            highReady_q <= 1'b0;
            fastWake_q  <= 1'b0;
            sysTick_q   <= 1'b0;
            cpuTick_q   <= 1'b0;
            subTick_q   <= 1'b0;
            wdtTick_q   <= 1'b0;
            highTick_q  <= 1'b0;
            highOn_q    <= 1'b1;
            subOn_q     <= 1'b1;
        end else begin
            mode_q      <= mode_d;
            src_q       <= src_d;
            subCnt_q    <= subCnt_d;
            divCnt_q    <= divCnt_d;
            startCnt_q  <= startCnt_d;
            wdtCnt_q    <= wdtCnt_d;
            highReady_q <= highReady_d;
            fastWake_q  <= fastWake_d;
            sysTick_q   <= sysTick_d;
            cpuTick_q   <= cpuTick_d;
            subTick_q   <= subTick_d;
            wdtTick_q   <= wdtTick_d;
            highTick_q  <= highTick_d;
            highOn_q    <= highOn_d;
            subOn_q     <= subOn_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, oscillator enables fixed by configuration

    assign sysClkTick      = sysTick_q;
    assign cpuClkTick      = cpuTick_q;
    assign subClkTick      = subTick_q;
    assign watchdogClkTick = wdtTick_q;
    assign highClkTick     = highTick_q;
    assign highReady       = highReady_q;
    assign operatingMode   = mode_q;
    assign highCrystalOscEn = highOn_q & (HIGH_OSC_CFG == scp_pkg::OSC_CRYSTAL);
    assign highRcOscEn      = highOn_q & (HIGH_OSC_CFG == scp_pkg::OSC_RC);
    assign lowCrystalOscEn  = subOn_q & (LOW_OSC_CFG == scp_pkg::OSC_CRYSTAL);
    assign lowRcOscEn       = subOn_q & (LOW_OSC_CFG == scp_pkg::OSC_RC);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_deep_no_sub: assert property (@(posedge clk) disable iff (rst)
        mode_q == scp_pkg::MODE_DEEP_HALT |=> !subClkTick && !watchdogClkTick)
        else $error("clock active in deep halt");

    a_deep_refused: assert property (@(posedge clk) disable iff (rst)
        running && haltExec && (voltageDetectEnable || lcdDriverEnable)
        |=> mode_q != scp_pkg::MODE_DEEP_HALT)
        else $error("deep halt entered with detect or lcd on");

    a_sleep_choice: assert property (@(posedge clk) disable iff (rst)
        running && haltExec && !idleOnHaltEnable
        |=> mode_q inside {scp_pkg::MODE_DEEP_HALT, scp_pkg::MODE_HALT_SUB})
        else $error("halt with idle low did not sleep");

    a_idle_off: assert property (@(posedge clk) disable iff (rst)
        running && haltExec && idleOnHaltEnable
        && !systemControlReg[scp_pkg::IDLE_KEEP_BIT]
        |=> mode_q == scp_pkg::MODE_IDLE_OFF ##1 !sysClkTick)
        else $error("idle off mode wrong");

    a_idle_on: assert property (@(posedge clk) disable iff (rst)
        running && haltExec && idleOnHaltEnable
        && systemControlReg[scp_pkg::IDLE_KEEP_BIT]
        |=> mode_q == scp_pkg::MODE_IDLE_ON)
        else $error("idle on mode not entered");

    a_cpu_stopped: assert property (@(posedge clk) disable iff (rst)
        !running |=> !cpuClkTick)
        else $error("cpu clock in low power mode");

    a_slow_high_off: assert property (@(posedge clk) disable iff (rst)
        mode_q == scp_pkg::MODE_SLOW && $past(mode_q) == scp_pkg::MODE_SLOW
        |-> !highCrystalOscEn && !highRcOscEn)
        else $error("high oscillator on in slow mode");

    a_sub_period: assert property (@(posedge clk) disable iff (rst)
        subClkTick |=> !subClkTick)
        else $error("sub clock tick wider than one cycle");

    a_wdt_idle_off: assert property (@(posedge clk) disable iff (rst)
        mode_q == scp_pkg::MODE_IDLE_OFF && !watchdogSrcSub
        && $past(mode_q) == scp_pkg::MODE_IDLE_OFF |=> !watchdogClkTick)
        else $error("watchdog clock on in idle off from sysclk");

    a_half_ratio: assert property (@(posedge clk) disable iff (rst)
        sysClkTick && src_q == 3'h6 && $past(src_q) == 3'h6
        && $past(src_q, 2) == 3'h6 |=> !sysClkTick)
        else $error("divide by two ticks back to back");

endmodule : scp_clock_power

// >>> sim/scp_consumer_model.sv
// Peripheral clock consumer model counting the ticks handed out
`timescale 1ns/1ns

module scp_consumer_model (
    input  wire logic        clk,
    input  wire logic        clear,
    input  wire logic        sysClkTick,
    input  wire logic        cpuClkTick,
    input  wire logic        subClkTick,
    input  wire logic        watchdogClkTick,
    input  wire logic        highClkTick,
    output logic      [15:0] sysCnt,
    output logic      [15:0] cpuCnt,
    output logic      [15:0] subCnt,
    output logic      [15:0] wdtCnt,
    output logic      [15:0] hiCnt
);
    ////////////////////////////////////////////////////////////////////////
    // Consumers count every tick
    // Counts only, so a stretched or missing tick shows as a wrong total
    always_ff @(posedge clk) begin
        if (clear) begin
            sysCnt <= 16'h0000;
            cpuCnt <= 16'h0000;
            subCnt <= 16'h0000;
            wdtCnt <= 16'h0000;
            hiCnt  <= 16'h0000;
        end else begin
            sysCnt <= sysCnt + 16'(sysClkTick);
            cpuCnt <= cpuCnt + 16'(cpuClkTick);
            subCnt <= subCnt + 16'(subClkTick);
            wdtCnt <= wdtCnt + 16'(watchdogClkTick);
            hiCnt  <= hiCnt + 16'(highClkTick);
        end
    end
endmodule : scp_consumer_model

// >>> sim/system_clock_and_power_modes_tb.sv
// Self-checking bench for the clock selection and mode sequencer
`timescale 1ns/1ns

module system_clock_and_power_modes_tb;
    logic clk = 1'b0, rst = 1'b1, hl = 1'b1, idle = 1'b0, lvd = 1'b0;
    logic lcd = 1'b0, wdEn = 1'b0, wdSub = 1'b0, fast = 1'b0;
    logic halt = 1'b0, wake = 1'b0, clear = 1'b0;
    logic [2:0] cks = 3'h7;
    logic [7:0] sysCtl = 8'h00;
    logic sysT, cpuT, subT, wdT, hiT, hxEn, hrEn, lxEn, lrEn, hiRdy;
    logic [2:0] mode;
    logic [15:0] sysC, cpuC, subC, wdC, hiC;
    int error_cnt = 0;
    int n_checks = 0;

    always #20 clk = ~clk;

    // Small counts keep the run short
    scp_clock_power #(.SUB_DIV(8), .HS_START(16)) dut (
        .clk(clk), .rst(rst), .highLowClockSelect(hl),
        .clockDividerSelect(cks), .idleOnHaltEnable(idle),
        .systemControlReg(sysCtl), .voltageDetectEnable(lvd),
        .lcdDriverEnable(lcd), .watchdogEnable(wdEn),
        .watchdogSrcSub(wdSub), .fastWakeEnable(fast), .haltExec(halt),
        .wakeUp(wake), .sysClkTick(sysT), .cpuClkTick(cpuT),
        .subClkTick(subT), .watchdogClkTick(wdT), .highClkTick(hiT),
        .highCrystalOscEn(hxEn), .highRcOscEn(hrEn),
        .lowCrystalOscEn(lxEn), .lowRcOscEn(lrEn), .highReady(hiRdy),
        .operatingMode(mode));

    scp_consumer_model partner (
        .clk(clk), .clear(clear), .sysClkTick(sysT), .cpuClkTick(cpuT),
        .subClkTick(subT), .watchdogClkTick(wdT), .highClkTick(hiT),
        .sysCnt(sysC), .cpuCnt(cpuC), .subCnt(subC), .wdtCnt(wdC),
        .hiCnt(hiC));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkIn(input logic [15:0] got, input int lo, input int hi);
        n_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h..%h", $time, got,
                     lo, hi);
        end
    endtask : chkIn

    task automatic measure(input int n);
        @(negedge clk) clear = 1'b1;
        @(negedge clk) clear = 1'b0;
        repeat (n) @(negedge clk);
    endtask : measure

    task automatic pulse(input logic isHalt);
        @(negedge clk);
        if (isHalt) halt = 1'b1;
        else wake = 1'b1;
        @(negedge clk);
        halt = 1'b0;
        wake = 1'b0;
    endtask : pulse

    // Bounded wait: a high clock that never settles is a mismatch
    task automatic waitRdy();
        int i;
        for (i = 0; i < 200 && hiRdy !== 1'b1; i++) @(negedge clk);
        chk(16'(hiRdy), 16'h0001);
        // After fast wake the switch back waits for a sub tick
        repeat (12) @(negedge clk);
    endtask : waitRdy

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400_000;
        error_cnt++;
        stop_test();
    end

    initial begin
        int c;
        int e;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk(16'(mode), 16'(scp_pkg::MODE_NORMAL));
        chk(16'(hiRdy), 16'h0000);
        chk(16'({hxEn, hrEn, lxEn, lrEn}), 16'h000a);
        waitRdy();
        measure(256);
        chk(sysC, 16'h0100);
        chk(hiC, 16'h0100);
        chkIn(wdC, 63, 65);
        chkIn(subC, 31, 33);
        $display("Test reset done");
        hl = 1'b0;
        for (c = 7; c >= 2; c--) begin
            cks = 3'(c);
            repeat (130) @(negedge clk);
            measure(256);
            e = 256 >> (8 - c);
            chkIn(sysC, e - 1, e + 1);
            chk(16'(mode), 16'(scp_pkg::MODE_NORMAL));
        end
        for (c = 1; c >= 0; c--) begin
            cks = 3'(c);
            repeat (130) @(negedge clk);
            chk(16'(mode), 16'(scp_pkg::MODE_SLOW));
            chk(16'(hxEn), 16'h0000);
            measure(256);
            chkIn(sysC, 31, 33);
            chk(hiC, 16'h0000);
        end
        hl = 1'b1;
        waitRdy();
        chk(16'(mode), 16'(scp_pkg::MODE_NORMAL));
        $display("Test selection done");
        pulse(1'b1);
        chk(16'(mode), 16'(scp_pkg::MODE_DEEP_HALT));
        measure(64);
        chk(subC | wdC | cpuC, 16'h0000);
        chk(16'(lxEn), 16'h0000);
        pulse(1'b1);
        chk(16'(mode), 16'(scp_pkg::MODE_DEEP_HALT));
        pulse(1'b0);
        chk(16'(mode), 16'(scp_pkg::MODE_NORMAL));
        waitRdy();
        pulse(1'b0);
        chk(16'(mode), 16'(scp_pkg::MODE_NORMAL));
        $display("Test deep halt done");
        wdSub = 1'b1;
        for (c = 0; c < 3; c++) begin
            lvd = (c == 0);
            lcd = (c == 1);
            wdEn = (c == 2);
            pulse(1'b1);
            chk(16'(mode), 16'(scp_pkg::MODE_HALT_SUB));
            measure(64);
            chkIn(subC, 7, 9);
            chkIn(wdC, 1, 64);
            chk(cpuC, 16'h0000);
            pulse(1'b0);
            waitRdy();
        end
        // Software clears detect and LCD before an idle halt
        lvd = 1'b0;
        lcd = 1'b0;
        $display("Test halt sub done");
        idle = 1'b1;
        sysCtl = 8'h7f;
        for (c = 0; c < 2; c++) begin
            wdSub = 1'(c);
            fast = 1'(c);
            pulse(1'b1);
            chk(16'(mode), 16'(scp_pkg::MODE_IDLE_OFF));
            measure(64);
            chk(sysC | cpuC, 16'h0000);
            chkIn(subC, 7, 9);
            if (c == 1) chkIn(wdC, 1, 64);
            else chk(wdC, 16'h0000);
            chk(16'(hxEn), 16'h0000);
            pulse(1'b0);
            if (c == 1) begin
                measure(12);
                chkIn(cpuC, 1, 2);
            end
            waitRdy();
        end
        $display("Test idle off done");
        fast = 1'b0;
        wdSub = 1'b0;
        sysCtl = 8'h80;
        pulse(1'b1);
        sysCtl = 8'h00;
        idle = 1'b0;
        chk(16'(mode), 16'(scp_pkg::MODE_IDLE_ON));
        measure(64);
        chk(sysC, 16'h0040);
        chk(cpuC, 16'h0000);
        chkIn(wdC, 15, 17);
        chk(16'(mode), 16'(scp_pkg::MODE_IDLE_ON));
        pulse(1'b0);
        chk(16'(mode), 16'(scp_pkg::MODE_NORMAL));
        $display("Test idle on done");
        stop_test();
    end
endmodule : system_clock_and_power_modes_tb
